// [ais_pkg.sv]
// Package for the converter input-select and pin-configuration register slice.
package ais_pkg;

  // Register byte offsets; a group of four words is plain, clear, set, invert.
  localparam logic [7:0] AIS_CTRL3_ADDR = 8'h00;
  localparam logic [7:0] AIS_CTRL3_CLR_ADDR = 8'h04;
  localparam logic [7:0] AIS_CTRL3_SET_ADDR = 8'h08;
  localparam logic [7:0] AIS_CTRL3_INV_ADDR = 8'h0C;
  localparam logic [7:0] AIS_CHS_ADDR = 8'h10;
  localparam logic [7:0] AIS_CHS_CLR_ADDR = 8'h14;
  localparam logic [7:0] AIS_CHS_SET_ADDR = 8'h18;
  localparam logic [7:0] AIS_CHS_INV_ADDR = 8'h1C;
  localparam logic [7:0] AIS_PCFG_ADDR = 8'h20;
  localparam logic [7:0] AIS_PCFG_CLR_ADDR = 8'h24;
  localparam logic [7:0] AIS_PCFG_SET_ADDR = 8'h28;
  localparam logic [7:0] AIS_PCFG_INV_ADDR = 8'h2C;
  localparam logic [7:0] AIS_SMPCTL_ADDR = 8'h30;
  localparam logic [7:0] AIS_STATUS_ADDR = 8'h34;

  // Writable bit masks; everything else is reserved and reads zero.
  localparam logic [31:0] AIS_CTRL3_MASK = 32'h0000_9FFF;
  localparam logic [31:0] AIS_CHS_MASK = 32'h8F8F_0000;
  localparam logic [31:0] AIS_PCFG_MASK = 32'h0000_FFFF;
  localparam logic [31:0] AIS_SMPCTL_MASK = 32'h0000_1001;
  localparam logic [31:0] AIS_RESET_VALUE = 32'h0000_0000;

  // Field positions inside the input-select and sample-control registers.
  localparam int AIS_MUXB_NEG_BIT = 31;
  localparam int AIS_MUXB_POS_LSB = 24;
  localparam int AIS_MUXA_NEG_BIT = 23;
  localparam int AIS_MUXA_POS_LSB = 16;
  localparam int AIS_ALTERNATE_SAMPLING_ENABLE_BIT = 0;
  localparam int AIS_OFFSET_CALIBRATION_ENABLE_BIT = 12;

  // Register group addressed by bits 7:4 and operation by bits 3:2.
  typedef enum logic [2:0] {
    AIS_T_CTRL3 = 3'h0,
    AIS_T_CHS = 3'h1,
    AIS_T_PCFG = 3'h2,
    AIS_T_SMPCTL = 3'h3,
    AIS_T_STATUS = 3'h4,
    AIS_T_NONE = 3'h5
  } ais_target_e;

  typedef enum logic [1:0] {
    AIS_OP_WRITE = 2'h0,
    AIS_OP_CLEAR = 2'h1,
    AIS_OP_SET = 2'h2,
    AIS_OP_INVERT = 2'h3
  } ais_op_e;

  // Multiplexer setting in use; Gray order A then B.
  typedef enum logic {
    AIS_MUX_A = 1'b0,
    AIS_MUX_B = 1'b1
  } ais_mux_e;

  typedef struct packed {
    ais_target_e target;
    ais_op_e op;
  } ais_decode_s;

  // Route handed to the sample-and-hold input multiplexers.
  typedef struct packed {
    logic [3:0] positive_input;
    logic positive_to_negative_reference;
    logic negative_to_input_one;
  } ais_route_s;

endpackage : ais_pkg

// [ais_regs.sv]
// Input-select, pin-configuration and control-three registers with alias writes.
`timescale 1ns/100ps
module ais_regs
  import ais_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic sample_strobe,
  input wire logic [15:0] pin_level,
  output logic [15:0] pin_digital_mode,
  output logic [15:0] port_read_data,
  output ais_route_s route,
  output logic [7:0] ctrl3_clock_select,
  output logic [4:0] ctrl3_sample_time,
  output logic ctrl3_rc_clock
);

  // Address decode, shared by the write path and the read path.
  function automatic ais_decode_s decode(input logic [7:0] addr);
    ais_decode_s d;
    d.op = ais_op_e'(addr[3:2]);
    d.target = AIS_T_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[7:4])
        4'h0: d.target = AIS_T_CTRL3;
        4'h1: d.target = AIS_T_CHS;
        4'h2: d.target = AIS_T_PCFG;
        4'h3:
        begin
          if (addr == AIS_SMPCTL_ADDR)
            d.target = AIS_T_SMPCTL;
          else if (addr == AIS_STATUS_ADDR)
            d.target = AIS_T_STATUS;
        end
        default: d.target = AIS_T_NONE;
      endcase
    end
    return d;
  endfunction : decode

  // Next value of a register under a plain or alias write.
  // Only masked bits ever move, so reserved bits stay zero whatever is written.
  function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] wd,
                                        input ais_op_e op, input logic [31:0] mask);
    logic [31:0] sel;
    sel = wd & mask;
    case (op)
      AIS_OP_CLEAR: apply = old & ~sel;
      AIS_OP_SET: apply = old | sel;
      AIS_OP_INVERT: apply = old ^ sel;
      default: apply = (old & ~mask) | sel;
    endcase
  endfunction : apply

  ais_decode_s wr_dec;
  ais_decode_s rd_dec;
  logic [31:0] ctrl3_reg;
  logic [31:0] chs_reg;
  logic [31:0] pcfg_reg;
  logic [31:0] smpctl_reg;
  logic [31:0] ctrl3_next;
  logic [31:0] chs_next;
  logic [31:0] pcfg_next;
  logic [31:0] smpctl_next;
  ais_mux_e mux_reg;
  ais_mux_e mux_next;
  logic [15:0] pin_meta_reg;
  logic [15:0] pin_sync_reg;
  logic [15:0] port_read_reg;
  ais_route_s route_reg;
  ais_route_s route_next;
  logic [31:0] rdata_reg;
  logic alternate_sampling_enable;
  logic offset_calibration_enable;

  assign wr_dec = decode(reg_addr);
  assign rd_dec = decode(reg_addr);
  assign alternate_sampling_enable = smpctl_reg[AIS_ALTERNATE_SAMPLING_ENABLE_BIT];
  assign offset_calibration_enable = smpctl_reg[AIS_OFFSET_CALIBRATION_ENABLE_BIT];

  // Each target computes its whole next word at once, so an alias write
  // is a single read-modify-write that nothing can observe half done.
  always_comb
  begin
    ctrl3_next = ctrl3_reg;
    chs_next = chs_reg;
    pcfg_next = pcfg_reg;
    smpctl_next = smpctl_reg;
    if (reg_write)
    begin
      case (wr_dec.target)
        AIS_T_CTRL3: ctrl3_next = apply(ctrl3_reg, reg_wdata, wr_dec.op, AIS_CTRL3_MASK);
        AIS_T_CHS: chs_next = apply(chs_reg, reg_wdata, wr_dec.op, AIS_CHS_MASK);
        AIS_T_PCFG: pcfg_next = apply(pcfg_reg, reg_wdata, wr_dec.op, AIS_PCFG_MASK);
        AIS_T_SMPCTL:
        begin
          if (wr_dec.op == AIS_OP_WRITE)
            smpctl_next = reg_wdata & AIS_SMPCTL_MASK;
        end
        default: ctrl3_next = ctrl3_reg;
      endcase
    end
  end

  // Register storage, all cleared at power-on.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl3_reg <= AIS_RESET_VALUE;
      chs_reg <= AIS_RESET_VALUE;
      pcfg_reg <= AIS_RESET_VALUE;
      smpctl_reg <= AIS_RESET_VALUE;
    end
    else
    begin
      ctrl3_reg <= ctrl3_next;
      chs_reg <= chs_next;
      pcfg_reg <= pcfg_next;
      smpctl_reg <= smpctl_next;
    end
  end

  // Read data stands one cycle after the strobe; aliases and holes read zero.
  // The status word sits where a clear alias would, so it is let through by target.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= AIS_RESET_VALUE;
    else if (reg_read && (rd_dec.op == AIS_OP_WRITE || rd_dec.target == AIS_T_STATUS))
    begin
      case (rd_dec.target)
        AIS_T_CTRL3: rdata_reg <= ctrl3_reg;
        AIS_T_CHS: rdata_reg <= chs_reg;
        AIS_T_PCFG: rdata_reg <= pcfg_reg;
        AIS_T_SMPCTL: rdata_reg <= smpctl_reg;
        AIS_T_STATUS: rdata_reg <= {31'h0000_0000, mux_reg};
        default: rdata_reg <= AIS_RESET_VALUE;
      endcase
    end
    else
      rdata_reg <= AIS_RESET_VALUE;
  end

  // Setting A is used first; each sample then swaps while alternation is on.
  always_comb
  begin
    mux_next = mux_reg;
    if (!alternate_sampling_enable)
      mux_next = AIS_MUX_A;
    else if (sample_strobe)
    begin
      case (mux_reg)
        AIS_MUX_A: mux_next = AIS_MUX_B;
        AIS_MUX_B: mux_next = AIS_MUX_A;
        default: mux_next = AIS_MUX_A;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mux_reg <= AIS_MUX_A;
    else
      mux_reg <= mux_next;
  end

  // Route for the sample after this one; calibration wins over the selects.
  always_comb
  begin
    route_next.positive_input = chs_reg[AIS_MUXA_POS_LSB +: 4];
    route_next.positive_to_negative_reference = 1'b0;
    route_next.negative_to_input_one = chs_reg[AIS_MUXA_NEG_BIT];
    if (mux_next == AIS_MUX_B)
    begin
      route_next.positive_input = chs_reg[AIS_MUXB_POS_LSB +: 4];
      route_next.negative_to_input_one = chs_reg[AIS_MUXB_NEG_BIT];
    end
    if (offset_calibration_enable)
    begin
      route_next.positive_input = 4'h0;
      route_next.positive_to_negative_reference = 1'b1;
      route_next.negative_to_input_one = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      route_reg <= '0;
    else
      route_reg <= route_next;
  end

  // Pin levels come from outside and pass two flops before use.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta_reg <= 16'h0000;
      pin_sync_reg <= 16'h0000;
    end
    else
    begin
      pin_meta_reg <= pin_level;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Per-pin port read: live in digital mode, forced high in analog mode.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_pin
      always_ff @(posedge clock or negedge rstn)
      begin
        if (!rstn)
          port_read_reg[gi] <= 1'b1;
        else if (pcfg_reg[gi])
          port_read_reg[gi] <= pin_sync_reg[gi];
        else
          port_read_reg[gi] <= 1'b1;
      end
    end
  endgenerate

  // A digital pin feeds ground to the converter; the mux reads this mask.
  assign pin_digital_mode = pcfg_reg[15:0];
  assign port_read_data = port_read_reg;
  assign route = route_reg;
  assign reg_rdata = rdata_reg;
  assign ctrl3_clock_select = ctrl3_reg[7:0];
  assign ctrl3_sample_time = ctrl3_reg[12:8];
  assign ctrl3_rc_clock = ctrl3_reg[15];

  // Checks on alias behaviour, field routing and pin modes.
  sequence s_ctrl3_alias(ais_op_e op);
    reg_write && wr_dec.target == AIS_T_CTRL3 && wr_dec.op == op;
  endsequence

  property p_ctrl3_clear;
    @(posedge clock) disable iff (!rstn)
    s_ctrl3_alias(AIS_OP_CLEAR) |=>
      ctrl3_reg == ($past(ctrl3_reg) & ~($past(reg_wdata) & AIS_CTRL3_MASK));
  endproperty
  a_ctrl3_clear: assert property (p_ctrl3_clear) else $error("ctrl3 clear alias wrong");

  property p_ctrl3_set;
    @(posedge clock) disable iff (!rstn)
    s_ctrl3_alias(AIS_OP_SET) |=>
      ctrl3_reg == ($past(ctrl3_reg) | ($past(reg_wdata) & AIS_CTRL3_MASK));
  endproperty
  a_ctrl3_set: assert property (p_ctrl3_set) else $error("ctrl3 set alias wrong");

  property p_ctrl3_invert;
    @(posedge clock) disable iff (!rstn)
    s_ctrl3_alias(AIS_OP_INVERT) |=>
      ctrl3_reg == ($past(ctrl3_reg) ^ ($past(reg_wdata) & AIS_CTRL3_MASK));
  endproperty
  a_ctrl3_invert: assert property (p_ctrl3_invert) else $error("ctrl3 invert wrong");

  property p_zero_keeps;
    @(posedge clock) disable iff (!rstn)
    reg_write && wr_dec.op != AIS_OP_WRITE && reg_wdata == 32'h0000_0000 |=>
      $stable(ctrl3_reg) && $stable(chs_reg) && $stable(pcfg_reg);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero alias changed a reg");

  property p_reserved_zero;
    @(posedge clock) disable iff (!rstn)
    (ctrl3_reg & ~AIS_CTRL3_MASK) == 32'h0000_0000 && (chs_reg & ~AIS_CHS_MASK) == 32'h0000_0000
      && (pcfg_reg & ~AIS_PCFG_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_chs_set;
    @(posedge clock) disable iff (!rstn)
    reg_write && reg_addr == AIS_CHS_SET_ADDR |=>
      chs_reg == ($past(chs_reg) | ($past(reg_wdata) & AIS_CHS_MASK));
  endproperty
  a_chs_set: assert property (p_chs_set) else $error("input select set wrong");

  property p_pcfg_invert;
    @(posedge clock) disable iff (!rstn)
    reg_write && reg_addr == AIS_PCFG_INV_ADDR |=>
      pcfg_reg == ($past(pcfg_reg) ^ ($past(reg_wdata) & AIS_PCFG_MASK));
  endproperty
  a_pcfg_invert: assert property (p_pcfg_invert) else $error("pin config invert wrong");

  property p_route_b;
    @(posedge clock) disable iff (!rstn)
    mux_reg == AIS_MUX_B && !$past(offset_calibration_enable) && $stable(chs_reg) |->
      route.positive_input == chs_reg[AIS_MUXB_POS_LSB +: 4]
      && route.negative_to_input_one == chs_reg[AIS_MUXB_NEG_BIT];
  endproperty
  a_route_b: assert property (p_route_b) else $error("setting B route wrong");

  property p_route_a;
    @(posedge clock) disable iff (!rstn)
    !alternate_sampling_enable && !offset_calibration_enable && !sample_strobe |=>
      route.positive_input == $past(chs_reg[AIS_MUXA_POS_LSB +: 4])
      && route.negative_to_input_one == $past(chs_reg[AIS_MUXA_NEG_BIT]);
  endproperty
  a_route_a: assert property (p_route_a) else $error("setting A route wrong");

  property p_alternate;
    @(posedge clock) disable iff (!rstn)
    alternate_sampling_enable && $past(alternate_sampling_enable) && sample_strobe |=> mux_reg != $past(mux_reg);
  endproperty
  a_alternate: assert property (p_alternate) else $error("setting did not alternate");

  property p_offset_calibration_enable;
    @(posedge clock) disable iff (!rstn)
    offset_calibration_enable |=> route.positive_to_negative_reference && !route.negative_to_input_one;
  endproperty
  a_offset_calibration_enable: assert property (p_offset_calibration_enable) else $error("calibration route wrong");

  property p_analog_reads_one;
    @(posedge clock) disable iff (!rstn)
    pcfg_reg[0] == 1'b0 |=> port_read_data[0];
  endproperty
  a_analog_reads_one: assert property (p_analog_reads_one) else $error("analog pin read low");

endmodule : ais_regs

// [ais_regs_test.sv]
// Self-checking testbench for the converter input-select register slice.
`timescale 1ns/100ps
module ais_regs_test
  import ais_pkg::*;
  ;

  logic clock;
  logic rstn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic sample_strobe;
  logic [15:0] pin_level;
  logic [15:0] pin_digital_mode;
  logic [15:0] port_read_data;
  ais_route_s route;
  logic [7:0] ctrl3_clock_select;
  logic [4:0] ctrl3_sample_time;
  logic ctrl3_rc_clock;
  int failures;
  int n_tests;

  ais_regs i_dut (
    .clock(clock),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .sample_strobe(sample_strobe),
    .pin_level(pin_level),
    .pin_digital_mode(pin_digital_mode),
    .port_read_data(port_read_data),
    .route(route),
    .ctrl3_clock_select(ctrl3_clock_select),
    .ctrl3_sample_time(ctrl3_sample_time),
    .ctrl3_rc_clock(ctrl3_rc_clock)
  );

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // Case equality keeps an unknown from passing as a match.
  task automatic chk(input logic [31:0] seen, input logic [31:0] expected);
    n_tests++;
    if (seen !== expected)
    begin
      failures++;
      $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, expected);
    end
  endtask : chk

  // One-cycle write strobe; a gap cycle follows so the strobe never doubles up.
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look just after that edge.
  task automatic rd(input logic [7:0] addr, input logic [31:0] expected);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= addr;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, expected);
  endtask : rd

  // Covers the register-to-route delay and the three-stage pin path.
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask : settle

  task automatic strobe();
    @(posedge clock);
    sample_strobe <= 1'b1;
    @(posedge clock);
    sample_strobe <= 1'b0;
    settle();
  endtask : strobe

  function automatic ais_route_s rt(input logic [3:0] p, input logic r, input logic n);
    rt = {p, r, n};
  endfunction : rt

  task automatic chk_route(input ais_route_s expected);
    chk({26'h000_0000, route}, {26'h000_0000, expected});
  endtask : chk_route

  task automatic print_verdict();
    $display("failures %0d, n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Cuts a hang short; the whole sequence needs well under a thousand cycles.
  initial
  begin
    #50000;
    failures++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    print_verdict();
  end

  // Main sequence of register accesses and route checks.
  initial
  begin
    logic [3:0] k;
    clock = 1'b0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sample_strobe = 1'b0;
    pin_level = 16'h1234;
    failures = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(AIS_CTRL3_ADDR, AIS_RESET_VALUE);
    rd(AIS_CHS_ADDR, AIS_RESET_VALUE);
    rd(AIS_PCFG_ADDR, AIS_RESET_VALUE);
    chk_route(rt(4'h0, 1'b0, 1'b0));
    chk({16'h0000, pin_digital_mode}, 32'h0000_0000);
    chk({16'h0000, port_read_data}, 32'h0000_FFFF);
    // Control three: ones in reserved places must never stick.
    wr(AIS_CTRL3_ADDR, 32'hFFFF_FFFF);
    rd(AIS_CTRL3_ADDR, 32'h0000_9FFF);
    wr(AIS_CTRL3_CLR_ADDR, 32'hFFFF_8001);
    rd(AIS_CTRL3_ADDR, 32'h0000_1FFE);
    wr(AIS_CTRL3_SET_ADDR, 32'h0000_8000);
    rd(AIS_CTRL3_ADDR, 32'h0000_9FFE);
    wr(AIS_CTRL3_INV_ADDR, 32'hFFFF_9003);
    rd(AIS_CTRL3_ADDR, 32'h0000_0FFD);
    chk({16'h0000, ctrl3_rc_clock, 2'b00, ctrl3_sample_time, ctrl3_clock_select},
        32'h0000_0FFD);
    // Input select and its aliases.
    wr(AIS_CHS_SET_ADDR, 32'hFFFF_FFFF);
    rd(AIS_CHS_ADDR, 32'h8F8F_0000);
    wr(AIS_CHS_CLR_ADDR, 32'h8001_0000);
    rd(AIS_CHS_ADDR, 32'h0F8E_0000);
    wr(AIS_CHS_SET_ADDR, 32'hF000_0001);
    rd(AIS_CHS_ADDR, 32'h8F8E_0000);
    wr(AIS_CHS_INV_ADDR, 32'h0101_0000);
    rd(AIS_CHS_ADDR, 32'h8E8F_0000);
    // Pin configuration and the port read path.
    wr(AIS_PCFG_SET_ADDR, 32'hFFFF_FFFF);
    rd(AIS_PCFG_ADDR, 32'h0000_FFFF);
    settle();
    chk({16'h0000, pin_digital_mode}, 32'h0000_FFFF);
    chk({16'h0000, port_read_data}, 32'h0000_1234);
    wr(AIS_PCFG_CLR_ADDR, 32'h0000_8001);
    settle();
    chk({16'h0000, port_read_data}, 32'h0000_9235);
    wr(AIS_PCFG_INV_ADDR, 32'hFFFF_0003);
    rd(AIS_PCFG_ADDR, 32'h0000_7FFD);
    wr(AIS_PCFG_SET_ADDR, 32'h0000_8000);
    rd(AIS_PCFG_ADDR, 32'h0000_FFFD);
    // An all-zero alias word must leave the register as it was.
    wr(AIS_PCFG_CLR_ADDR, 32'h0000_0000);
    rd(AIS_PCFG_ADDR, 32'h0000_FFFD);
    rd(AIS_PCFG_SET_ADDR, AIS_RESET_VALUE);
    @(posedge clock);
    pin_level <= 16'hEDC9;
    settle();
    chk({16'h0000, port_read_data}, 32'h0000_EDCB);
    rd(8'h40, 32'h0000_0000);
    // Every selector code on both settings, flipping between them by strobes.
    wr(AIS_SMPCTL_ADDR, 32'h0000_0001);
    for (int i = 0; i < 16; i++)
    begin
      k = i[3:0];
      wr(AIS_CHS_ADDR, {k[1], 3'b000, ~k, k[0], 3'b000, k, 16'h0000});
      settle();
      chk_route(rt(k, 1'b0, k[0]));
      strobe();
      chk_route(rt(~k, 1'b0, k[1]));
      strobe();
      chk_route(rt(k, 1'b0, k[0]));
    end
    strobe();
    chk_route(rt(4'h0, 1'b0, 1'b1));
    rd(AIS_STATUS_ADDR, 32'h0000_0001);
    wr(AIS_SMPCTL_ADDR, 32'h0000_0000);
    strobe();
    chk_route(rt(4'hF, 1'b0, 1'b1));
    // Calibration overrides the selection, and releasing it restores setting A.
    wr(AIS_SMPCTL_ADDR, 32'h0000_1000);
    settle();
    chk_route(rt(4'h0, 1'b1, 1'b0));
    wr(AIS_SMPCTL_ADDR, 32'h0000_0000);
    settle();
    chk_route(rt(4'hF, 1'b0, 1'b1));
    // A second reset in mid-run clears the registers and the route at once; the pin mode mask drops to zero.
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk_route(rt(4'h0, 1'b0, 1'b0));
    chk({16'h0000, pin_digital_mode}, 32'h0000_0000);
    @(posedge clock);
    rstn <= 1'b1;
    rd(AIS_CHS_ADDR, AIS_RESET_VALUE);
    print_verdict();
  end

endmodule : ais_regs_test
